/* rtl/fspa_pkg.sv */
// Package of constants and carrier types for the flash self-program sequencer
package fspa_pkg;
   localparam int unsigned ADDR_W          = 14;
   localparam int unsigned FLASH_BYTES     = 16384;
   localparam int unsigned PAGE_BYTES      = 512;
   localparam int unsigned PAGE_LSB        = 9;
   localparam int unsigned LOADER_STEP     = 512;
   localparam int unsigned LOADER_MAX_STEP = 15;
   localparam logic [2:0]  MODE_STANDBY    = 3'h0;
   localparam logic [2:0]  MODE_READ       = 3'h1;
   localparam logic [2:0]  MODE_PROGRAM    = 3'h2;
   localparam logic [2:0]  MODE_ERASE      = 3'h3;
   localparam logic [2:0]  MODE_TRIM_READ  = 3'h6;
   localparam logic [7:0]  TRIG_FIRST      = 8'h46;
   localparam logic [7:0]  TRIG_SECOND     = 8'hB9;
   localparam logic [7:0]  TRIM_ADDR_LOW   = 8'hC0;
   localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
   localparam logic [7:0]  RESET_BYTE      = 8'h00;
   localparam logic [5:0]  RESET_LOW_BOUND = 6'h00;
   // Flash array timing
   localparam int unsigned CLK_MHZ         = 250;
   localparam int unsigned PROG_TIME_NS    = 40;
   localparam int unsigned PROG_CYCLES     = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;

   // Processor register writes
   typedef struct packed {
      logic       mode_we;
      logic       addr_high_we;
      logic       addr_low_we;
      logic       data_we;
      logic       trigger_we;
      logic       low_bound_we;
      logic [7:0] wdata;
   } fspa_sfr_wr_t;

   // Request to the flash array
   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
   } fspa_flash_req_t;
endpackage : fspa_pkg

/* rtl/fspa_region_check.sv */
// Region permission check for erase and program targets
`timescale 1ns/1ps
`default_nettype none
module fspa_region_check
   import fspa_pkg::*;
(
   // Configuration
   input  wire logic [3:0]        loader_steps,
   input  wire logic [5:0]        low_bound_page,
   input  wire logic              running_loader,
   // Target
   input  wire logic [ADDR_W-1:0] target_addr,
   // Verdict
   output logic                   allowed,
   output logic                   in_data_region
);
   logic [ADDR_W:0] loader_start;
   logic [ADDR_W:0] data_start;
   logic [ADDR_W:0] target_ext;
   logic            in_app;
   logic            in_loader;

   // Loader sits at the top, data region just below it
   assign loader_start = (ADDR_W+1)'(FLASH_BYTES) - {2'b00, loader_steps, 9'h000};
   assign data_start   = {low_bound_page[4:0], 10'h000} >> 1;
   assign target_ext   = {1'b0, target_addr};
   assign in_loader    = target_ext >= loader_start;
   assign in_data_region = (target_ext >= data_start) && !in_loader;
   assign in_app       = !in_loader && !in_data_region;
   assign allowed      = running_loader ? (in_app || in_data_region)
                                        : in_data_region;
endmodule : fspa_region_check
`default_nettype wire

/* rtl/fspa_sequencer.sv */
// Flash self-program sequencer: mode select, unlock trigger and flash access
// Notes on behaviour
// - Application, data and loader regions share flash
// - Loader code may modify application and data
// - Application code may modify data region only
// - Loader size off or half-kilobyte steps
// - Data region from low bound to loader
// - Low bound from option or application software
// - Offers page erase, byte program, byte read
// - Mode 011 erases a 512-byte page
// - Mode 010 programs the data byte
// - Mode 001 reads byte into data register
// - Trigger pair 46 then B9 starts operation
// - High and low registers form the address
// - Mode 06 reads the byte at the address pair, like mode 001
// - Program clears bits; erase sets all ones
`timescale 1ns/1ps
`default_nettype none
module fspa_sequencer
   import fspa_pkg::*;
#(
   parameter int unsigned PROG_WAIT = PROG_CYCLES
)(
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  reset_n,
   input  wire logic                  clk_en,
   // Hardware options
   input  wire logic [3:0]            option_loader_steps,
   input  wire logic [5:0]            option_low_bound,
   input  wire logic                  running_loader,
   // Processor registers
   input  wire fspa_sfr_wr_t          sfr_wr,
   input  wire logic                  flash_access_control,
   output logic [2:0]                 access_mode_register,
   output logic [7:0]                 flash_addr_high,
   output logic [7:0]                 flash_addr_low,
   output logic [7:0]                 flash_data_byte,
   output logic [5:0]                 data_region_low_bound,
   output logic                       busy,
   output logic                       denied,
   // Flash array
   output fspa_flash_req_t            flash_req,
   output logic                       flash_erase,
   input  wire logic [7:0]            flash_rdata,
   input  wire logic                  flash_done
);
   initial begin
      if (PROG_WAIT < 1 || PROG_WAIT > 4096)
         $error("PROG_WAIT out of range");
   end

   typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_CHECK, ST_ERASE,
                             ST_PROG_RD, ST_PROG_WR, ST_READ, ST_WAIT} fspa_state_t;

   fspa_state_t       state;
   fspa_state_t       next_state;
   logic [8:0]        page_off;
   logic [12:0]       wait_cnt;
   logic [ADDR_W-1:0] target_addr;
   logic              allowed;
   logic              in_data;
   logic              is_first;
   logic              is_second;
   logic              trig_go;
   logic              mode_mod;
   logic              mode_rd;
   logic [7:0]        prog_value;

   fspa_region_check u_region (
      .loader_steps   (option_loader_steps),
      .low_bound_page (data_region_low_bound),
      .running_loader (running_loader),
      .target_addr    (target_addr),
      .allowed        (allowed),
      .in_data_region (in_data)
   );

   // Address pair; trim read uses the same address
   assign target_addr = (access_mode_register == MODE_TRIM_READ)
                        ? ADDR_W'({flash_addr_high, flash_addr_low})
                        : ADDR_W'({flash_addr_high, flash_addr_low});
   assign is_first    = sfr_wr.trigger_we && sfr_wr.wdata == TRIG_FIRST;
   assign is_second   = sfr_wr.trigger_we && sfr_wr.wdata == TRIG_SECOND;
   assign trig_go     = state == ST_ARMED && is_second && flash_access_control;
   assign mode_mod    = access_mode_register == MODE_ERASE
                     || access_mode_register == MODE_PROGRAM;
   assign mode_rd     = access_mode_register == MODE_READ
                     || access_mode_register == MODE_TRIM_READ;
   assign prog_value  = flash_rdata & flash_data_byte;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (is_first)
               next_state = ST_ARMED;
         end
         ST_ARMED: begin
            // Any other write breaks the pair; a repeated first trigger keeps it armed
            if (trig_go)
               next_state = ST_CHECK;
            else if (sfr_wr.trigger_we || sfr_wr.mode_we || sfr_wr.addr_high_we
                     || sfr_wr.addr_low_we || sfr_wr.data_we || sfr_wr.low_bound_we)
               next_state = is_first ? ST_ARMED : ST_IDLE;
         end
         ST_CHECK: begin
            if (mode_rd)
               next_state = ST_READ;
            else if (mode_mod && !allowed)
               next_state = ST_IDLE;
            else if (access_mode_register == MODE_ERASE)
               next_state = ST_ERASE;
            else if (access_mode_register == MODE_PROGRAM)
               next_state = ST_PROG_RD;
            else
               next_state = ST_IDLE;
         end
         ST_ERASE: begin
            if (page_off == 9'h1FF)
               next_state = ST_WAIT;
         end
         ST_PROG_RD: begin
            if (flash_done)
               next_state = ST_PROG_WR;
         end
         ST_PROG_WR: next_state = ST_WAIT;
         ST_READ: begin
            if (flash_done)
               next_state = ST_IDLE;
         end
         ST_WAIT: begin
            if (wait_cnt == 13'(PROG_WAIT - 1))
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // Page walk and settle counters
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         page_off <= 9'h000;
         wait_cnt <= 13'h0000;
      end else if (clk_en) begin
         page_off <= (state == ST_ERASE) ? page_off + 9'h001 : 9'h000;
         wait_cnt <= (state == ST_WAIT) ? wait_cnt + 13'h0001 : 13'h0000;
      end
   end

   // Software-visible registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         access_mode_register <= MODE_STANDBY;
         flash_addr_high      <= RESET_BYTE;
         flash_addr_low       <= RESET_BYTE;
         flash_data_byte      <= RESET_BYTE;
      end else if (clk_en) begin
         if (sfr_wr.mode_we && state != ST_CHECK)
            access_mode_register <= sfr_wr.wdata[2:0];
         if (sfr_wr.addr_high_we)
            flash_addr_high <= sfr_wr.wdata;
         if (sfr_wr.addr_low_we)
            flash_addr_low <= sfr_wr.wdata;
         if (state == ST_READ && flash_done)
            flash_data_byte <= flash_rdata;
         else if (sfr_wr.data_we)
            flash_data_byte <= sfr_wr.wdata;
      end
   end

   // Low bound: option at reset release, then application writes
   logic bound_loaded;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_region_low_bound <= RESET_LOW_BOUND;
         bound_loaded          <= 1'b0;
      end else if (clk_en) begin
         if (!bound_loaded) begin
            data_region_low_bound <= option_low_bound;
            bound_loaded          <= 1'b1;
         end else if (sfr_wr.low_bound_we && !running_loader) begin
            data_region_low_bound <= sfr_wr.wdata[5:0];
         end
      end
   end

   // Flash array request and status
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         flash_req   <= '0;
         flash_erase <= 1'b0;
         busy        <= 1'b0;
         denied      <= 1'b0;
      end else if (clk_en) begin
         flash_req.read  <= next_state == ST_READ || next_state == ST_PROG_RD;
         flash_req.write <= next_state == ST_ERASE || next_state == ST_PROG_WR;
         flash_erase     <= next_state == ST_ERASE;
         if (next_state == ST_ERASE)
            flash_req.addr <= {target_addr[ADDR_W-1:PAGE_LSB],
                               (state == ST_ERASE) ? page_off + 9'h001 : 9'h000};
         else
            flash_req.addr <= target_addr;
         flash_req.wdata <= (next_state == ST_ERASE) ? ERASED_BYTE : prog_value;
         busy            <= next_state != ST_IDLE && next_state != ST_ARMED;
         if (state == ST_CHECK)
            denied <= mode_mod && !allowed;
      end
   end
endmodule : fspa_sequencer
`default_nettype wire

/* verification/fspa_flash_model.sv */
// Behavioural flash array answering the sequencer's requests
`timescale 1ns/1ps
`default_nettype none
module fspa_flash_model
   import fspa_pkg::*;
(
   // Clock and pace
   input  wire logic            sys_clk,
   input  wire logic            slow,
   // Request and answer
   input  wire fspa_flash_req_t flash_req,
   input  wire logic            flash_erase,
   output logic [7:0]           flash_rdata = 8'h00,
   output logic                 flash_done = 1'b0
);
   logic [7:0]  mem [FLASH_BYTES];
   int unsigned wait_cnt = 0;
   initial begin
      for (int i = 0; i < FLASH_BYTES; i++) mem[i] = 8'(i ^ (i >> 6));
   end
   always @(posedge sys_clk) begin
      flash_done <= 1'b0;
      // No valid byte outside an answer
      flash_rdata <= ~flash_rdata;
      if (flash_req.write) begin
         mem[flash_req.addr] <= flash_erase ? ERASED_BYTE : mem[flash_req.addr] & flash_req.wdata;
      end
      if (flash_req.read && !flash_done) begin
         if (wait_cnt >= (slow ? 5 : 0)) begin
            flash_done  <= 1'b1;
            flash_rdata <= mem[flash_req.addr];
            wait_cnt    <= 0;
         end else begin
            wait_cnt <= wait_cnt + 1;
         end
      end
   end
endmodule : fspa_flash_model
`default_nettype wire

/* verification/fspa_sequencer_assertions.sv */
// Assertion checker for the flash self-program sequencer
`timescale 1ns/1ps
`default_nettype none
module fspa_sequencer_assertions
   import fspa_pkg::*;
(
   // Clock, options and writes
   input wire logic            sys_clk,
   input wire logic            reset_n,
   input wire logic [3:0]      option_loader_steps,
   input wire logic            running_loader,
   input wire fspa_sfr_wr_t    sfr_wr,
   input wire logic            flash_access_control,
   // Registers and flash side
   input wire logic [2:0]      access_mode_register,
   input wire logic [7:0]      flash_addr_high,
   input wire logic [7:0]      flash_addr_low,
   input wire logic [7:0]      flash_data_byte,
   input wire logic [5:0]      data_region_low_bound,
   input wire logic            busy,
   input wire logic            denied,
   input wire fspa_flash_req_t flash_req,
   input wire logic            flash_erase,
   input wire logic [7:0]      flash_rdata,
   input wire logic            flash_done
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire logic rd_mode = access_mode_register == MODE_READ || access_mode_register == MODE_TRIM_READ;
   wire logic below_loader = ({1'b0, flash_req.addr[13:9]} + {2'b00, option_loader_steps}) < 6'd32;
   sequence s_first;
      sfr_wr.trigger_we && sfr_wr.wdata == TRIG_FIRST && flash_access_control;
   endsequence
   sequence s_second;
      sfr_wr.trigger_we && sfr_wr.wdata == TRIG_SECOND && flash_access_control;
   endsequence
   sequence s_stray;
      sfr_wr.addr_low_we || sfr_wr.trigger_we && sfr_wr.wdata != TRIG_SECOND && sfr_wr.wdata != TRIG_FIRST;
   endsequence
   trig_starts_a: assert property (!busy && access_mode_register != MODE_STANDBY ##0 s_first ##1 s_second |=> busy)
      else $error("trigger pair did not start an operation");
   broken_pair_a: assert property (!busy ##0 s_first ##1 s_stray ##1 s_second |=> !busy)
      else $error("broken trigger pair started an operation");
   no_access_a: assert property (!busy && !flash_access_control |=> !busy)
      else $error("operation started with access disabled");
   read_lands_a: assert property (flash_done && flash_req.read && rd_mode |=> !busy && flash_data_byte == $past(flash_rdata))
      else $error("read byte not placed in data register");
   read_addr_a: assert property (flash_req.read && rd_mode |-> flash_req.addr == {flash_addr_high[5:0], flash_addr_low})
      else $error("read address differs from address pair");
   erase_ones_a: assert property (flash_erase && flash_req.write |-> flash_req.wdata == ERASED_BYTE && flash_req.addr[13:9] == flash_addr_high[5:1])
      else $error("erase write not all ones in the page");
   prog_clears_a: assert property (flash_req.write && !flash_erase |-> (flash_req.wdata & ~flash_data_byte) == 8'h00)
      else $error("program write sets a bit");
   loader_kept_a: assert property (flash_req.write |-> below_loader)
      else $error("write into loader region");
   app_data_only_a: assert property (flash_req.write && !running_loader |-> {1'b0, flash_req.addr[13:9]} >= data_region_low_bound)
      else $error("application code wrote outside data region");
   denied_quiet_a: assert property (denied |-> !flash_req.write)
      else $error("refused operation wrote flash");
endmodule : fspa_sequencer_assertions
bind fspa_sequencer fspa_sequencer_assertions u_chk (.sys_clk, .reset_n, .option_loader_steps,
   .running_loader, .sfr_wr, .flash_access_control, .access_mode_register, .flash_addr_high,
   .flash_addr_low, .flash_data_byte, .data_region_low_bound, .busy, .denied, .flash_req,
   .flash_erase, .flash_rdata, .flash_done);
`default_nettype wire

/* verification/fspa_sequencer_test.sv */
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/1ps
`default_nettype none
module fspa_sequencer_test
   import fspa_pkg::*;
;
   logic            sys_clk = 0, reset_n = 0, clk_en = 1, running_loader = 0, fac = 1, slow = 0;
   logic            busy, denied, flash_erase, flash_done;
   logic [5:0]      bound;
   logic [7:0]      dbyte, rdata, ahi;
   logic [2:0]      amode;
   fspa_sfr_wr_t    sfr_wr = '0;
   fspa_flash_req_t req;
   int              fail_count = 0, cmp_count = 0, cyc = 0;
   logic [7:0]      shadow [int];
   always #2 sys_clk = ~sys_clk;
   fspa_sequencer #(.PROG_WAIT(1)) uut (.sys_clk, .reset_n, .clk_en, .option_loader_steps(4'h3),
      .option_low_bound(6'h1B), .running_loader, .sfr_wr, .flash_access_control(fac),
      .access_mode_register(amode), .flash_addr_high(ahi), .flash_addr_low(),
      .flash_data_byte(dbyte),
      .data_region_low_bound(bound), .busy, .denied, .flash_req(req), .flash_erase,
      .flash_rdata(rdata), .flash_done);
   fspa_flash_model u_flash (.sys_clk, .slow, .flash_req(req), .flash_erase,
      .flash_rdata(rdata), .flash_done);
   function automatic logic [7:0] expv(int a);
      return shadow.exists(a) ? shadow[a] : 8'(a ^ (a >> 6));
   endfunction : expv
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(int k, logic [7:0] d);
      fspa_sfr_wr_t w;
      w = {6'h00, d};
      w[13-k] = 1'b1;
      sfr_wr = w;
      @(negedge sys_clk);
   endtask : wr
   task automatic op(logic [2:0] m, logic [15:0] a, logic [7:0] d);
      wr(0, {5'h00, m});
      wr(1, a[15:8]);
      wr(2, a[7:0]);
      wr(3, d);
      wr(4, TRIG_FIRST);
      wr(4, TRIG_SECOND);
      sfr_wr = '0;
      @(negedge sys_clk);
      while (busy !== 1'b0) @(negedge sys_clk);
   endtask : op
   task automatic prog(logic [15:0] a, logic [7:0] d, logic ok);
      op(MODE_PROGRAM, a, d);
      chk({7'h00, denied}, {7'h00, !ok});
      if (ok) shadow[a] = expv(a) & d;
      op(MODE_READ, a, 8'h00);
      chk(dbyte, expv(a));
   endtask : prog
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         test_done;
      end
   end
   initial begin
      void'($urandom(4));
      repeat (6) @(negedge sys_clk);
      reset_n = 1;
      repeat (2) @(negedge sys_clk);
      chk({2'h0, bound}, 8'h1B);
      repeat (6) begin
         slow = 1'($urandom);
         prog(16'h3600 + 16'($urandom % 1024), 8'($urandom), 1);
      end
      prog(16'h0100, 8'h00, 0);
      running_loader = 1;
      prog(16'h0100, 8'h0F, 1);
      prog(16'h3A00, 8'h00, 0);
      running_loader = 0;
      op(MODE_ERASE, 16'h3600, 8'h00);
      for (int i = 0; i < PAGE_BYTES; i++) shadow[16'h3600 + i] = ERASED_BYTE;
      prog(16'h37FF, 8'hA5, 1);
      wr(5, 8'h1A);
      sfr_wr = '0;
      @(negedge sys_clk);
      chk({2'h0, bound}, 8'h1A);
      prog(16'h3400, 8'h3C, 1);
      wr(4, TRIG_FIRST);
      wr(2, 8'h00);
      wr(4, TRIG_SECOND);
      wr(4, TRIG_FIRST);
      wr(4, 8'h47);
      wr(4, TRIG_SECOND);
      fac = 0;
      wr(4, TRIG_FIRST);
      wr(4, TRIG_SECOND);
      sfr_wr = '0;
      @(negedge sys_clk);
      chk({7'h00, busy}, 8'h00);
      fac = 1;
      chk({5'h00, amode}, {5'h00, MODE_READ});
      // Frozen clock enable must drop a register write
      clk_en = 0;
      wr(1, 8'h2A);
      sfr_wr = '0;
      clk_en = 1;
      @(negedge sys_clk);
      chk(ahi, 8'h34);
      for (int i = 0; i < 2; i++) begin
         op(MODE_TRIM_READ, {8'h00, TRIM_ADDR_LOW} + 16'(i), 8'h00);
         chk(dbyte, expv(16'h00C0 + i));
      end
      test_done;
   end
endmodule : fspa_sequencer_test
`default_nettype wire
